// ==== include/spm_pkg.sv ====
// package for the sleep and power manager
package spm_pkg;
  typedef enum logic [2:0] {
    SPM_MODE_IDLE = 3'h0,
    SPM_MODE_PDOWN = 3'h2,
    SPM_MODE_PSAVE = 3'h3,
    SPM_MODE_STDBY = 3'h6,
    SPM_MODE_ESTDBY = 3'h7
  } spm_mode_t;

  // gray along active -> sleep -> wake; wake -> active flips both bits
  typedef enum logic [1:0] {
    SPM_ST_ACTIVE = 2'h0,
    SPM_ST_SLEEP = 2'h1,
    SPM_ST_WAKE = 2'h3
  } spm_state_t;

  typedef struct packed {
    logic cpu;
    logic nvm;
    logic per;
    logic rtc;
    logic osc;
  } spm_clk_t;

  typedef struct packed {
    logic twi_match;
    logic pin_async;
    logic usb_resume;
  } spm_async_t;

  localparam int unsigned SPM_WAKE_HALT_CYC = 4;
  localparam logic [2:0] SPM_HALT_CNT_RST = 3'h0;
  localparam logic [2:0] SPM_MODE_RST = 3'h0;
endpackage : spm_pkg

// ==== logic/spm_sleep_ctrl.sv ====
// sleep mode controller with clock gating and wake handling
// Behaviour
// (RULE_01) five sleep modes, each entered from active
// (RULE_02) sleep instruction enters mode, stops execution
// (RULE_03) waking interrupt serviced, then resume after sleep
// (RULE_04) pending higher priority interrupts run first
// (RULE_05) core halted four cycles after wake
// (RULE_06) registers and memory retained while asleep
// (RULE_07) reset during sleep restarts at reset vector
// (RULE_08) enabled resets and interrupts wake device
// (RULE_09) idle stops cpu and nvm clocks only
// (RULE_10) idle wakes on any enabled interrupt
// (RULE_11) power-down stops every clock
// (RULE_12) power-down wakes on three async sources
// (RULE_13) pin change wakes from every mode
// (RULE_14) per-peripheral gating freezes peripheral state
// (RULE_15) per-peripheral gating applies in active, idle
// (RULE_16) usb suspend sleeps, resume wakes any mode
// (RULE_17) sleep enable and mode set before instruction
// (RULE_18) async wake latched clocklessly, restarts clocks
`timescale 1ns/100ps
`default_nettype none
module spm_sleep_ctrl #(
  parameter int unsigned NUM_PER = 8
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic sleep_instr,
  input wire logic sleep_en,
  input wire logic [2:0] sleep_mode,
  input wire logic nvm_busy,
  input wire logic irq_pending,
  input wire logic irq_sync_wake,
  input wire logic rst_src_req,
  input wire logic usb_suspend,
  input wire logic usb_sleep_req,
  input wire spm_pkg::spm_async_t async_wake,
  input wire logic [NUM_PER-1:0] per_off,
  output logic core_halt_ff,
  output logic core_reset_ff,
  output logic irq_service_ff,
  output logic asleep_ff,
  output spm_pkg::spm_clk_t clk_en_ff,
  output logic [NUM_PER-1:0] per_clk_en_ff
);
  spm_pkg::spm_state_t state_ff;
  spm_pkg::spm_state_t nxt_state;
  logic [2:0] mode_ff;
  logic [2:0] halt_cnt_ff;
  logic async_sync1_ff;
  logic async_sync2_ff;
  logic async_sync3_ff;
  logic async_lvl;
  logic wake_req;
  logic mode_idle;
  logic mode_pdown;
  logic mode_valid;

  // async sources are levels held by their own logic until served;
  // the or gate is clockless so it can restart a stopped oscillator
  assign async_lvl = |async_wake; // RULE_18

  // three-stage sync, second and third must agree
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      async_sync1_ff <= 1'b0;
      async_sync2_ff <= 1'b0;
      async_sync3_ff <= 1'b0;
    end else begin
      async_sync1_ff <= async_lvl;
      async_sync2_ff <= async_sync1_ff;
      async_sync3_ff <= async_sync2_ff;
    end
  end

  assign mode_idle = (mode_ff == spm_pkg::SPM_MODE_IDLE);
  assign mode_pdown = (mode_ff == spm_pkg::SPM_MODE_PDOWN);
  assign mode_valid = (sleep_mode == spm_pkg::SPM_MODE_IDLE) ||
                      (sleep_mode == spm_pkg::SPM_MODE_PDOWN) ||
                      (sleep_mode == spm_pkg::SPM_MODE_PSAVE) ||
                      (sleep_mode == spm_pkg::SPM_MODE_STDBY) ||
                      (sleep_mode == spm_pkg::SPM_MODE_ESTDBY); // RULE_01

  // pin, twi match and usb resume wake every mode; synchronous irqs
  // only where their clock still runs (not power-down)
  always_comb begin
    wake_req = async_sync2_ff && async_sync3_ff; // RULE_12 RULE_13 RULE_16
    if (!mode_pdown && irq_sync_wake) begin
      wake_req = 1'b1; // RULE_08 RULE_10
    end
  end

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      spm_pkg::SPM_ST_ACTIVE: begin
        if (((sleep_instr && sleep_en) || (usb_suspend && usb_sleep_req)) &&
            mode_valid) begin
          nxt_state = spm_pkg::SPM_ST_SLEEP; // RULE_02 RULE_16 RULE_17
        end
      end
      spm_pkg::SPM_ST_SLEEP: begin
        if (wake_req) begin
          nxt_state = spm_pkg::SPM_ST_WAKE;
        end
      end
      spm_pkg::SPM_ST_WAKE: begin
        if (halt_cnt_ff == 3'(spm_pkg::SPM_WAKE_HALT_CYC - 1)) begin
          nxt_state = spm_pkg::SPM_ST_ACTIVE; // RULE_05
        end
      end
      default: begin
        nxt_state = spm_pkg::SPM_ST_ACTIVE;
      end
    endcase
  end

  // reset source overrides any state: full restart, not resume
  always_ff @(posedge core_clk) begin
    if (!rstn || rst_src_req) begin
      state_ff <= spm_pkg::SPM_ST_ACTIVE; // RULE_07 RULE_08
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn || rst_src_req) begin
      core_reset_ff <= 1'b1; // RULE_07
    end else begin
      core_reset_ff <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      mode_ff <= spm_pkg::SPM_MODE_RST;
    end else if (state_ff == spm_pkg::SPM_ST_ACTIVE) begin
      mode_ff <= sleep_mode; // RULE_01
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      halt_cnt_ff <= spm_pkg::SPM_HALT_CNT_RST;
    end else if (state_ff == spm_pkg::SPM_ST_WAKE) begin
      halt_cnt_ff <= halt_cnt_ff + 3'h1; // RULE_05
    end else begin
      halt_cnt_ff <= spm_pkg::SPM_HALT_CNT_RST;
    end
  end

  // halt freezes the core; nothing here clears its state
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      core_halt_ff <= 1'b0;
      asleep_ff <= 1'b0;
    end else begin
      core_halt_ff <= (nxt_state != spm_pkg::SPM_ST_ACTIVE) && !rst_src_req; // RULE_02 RULE_06
      asleep_ff <= (nxt_state == spm_pkg::SPM_ST_SLEEP) && !rst_src_req;
    end
  end

  // one-cycle request to the interrupt controller after the halt;
  // it takes pending irqs in priority order, return lands after sleep
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      irq_service_ff <= 1'b0;
    end else begin
      irq_service_ff <= (state_ff == spm_pkg::SPM_ST_WAKE) &&
                        (nxt_state == spm_pkg::SPM_ST_ACTIVE) &&
                        irq_pending && !rst_src_req; // RULE_03 RULE_04
    end
  end

  // gating follows the next state so clocks stop with the halt
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      clk_en_ff <= '1;
    end else if (rst_src_req || nxt_state != spm_pkg::SPM_ST_SLEEP) begin
      clk_en_ff <= '1;
    end else begin
      clk_en_ff.cpu <= 1'b0; // RULE_09
      // ongoing programming finishes before nvm clock stops
      // idle only: the deeper modes stop the nvm clock, programming or not
      clk_en_ff.nvm <= nvm_busy && (state_ff == spm_pkg::SPM_ST_SLEEP ?
                       clk_en_ff.nvm : 1'b1) &&
                       (sleep_mode_q(state_ff, sleep_mode, mode_ff) ==
                        spm_pkg::SPM_MODE_IDLE); // RULE_09 RULE_11
      case (sleep_mode_q(state_ff, sleep_mode, mode_ff))
        spm_pkg::SPM_MODE_IDLE: begin
          clk_en_ff.per <= 1'b1;
          clk_en_ff.rtc <= 1'b1;
          clk_en_ff.osc <= 1'b1;
        end
        spm_pkg::SPM_MODE_PSAVE: begin
          clk_en_ff.per <= 1'b0;
          clk_en_ff.rtc <= 1'b1;
          clk_en_ff.osc <= 1'b0; // RULE_18
        end
        spm_pkg::SPM_MODE_STDBY: begin
          clk_en_ff.per <= 1'b0;
          clk_en_ff.rtc <= 1'b0;
          clk_en_ff.osc <= 1'b1; // RULE_18
        end
        spm_pkg::SPM_MODE_ESTDBY: begin
          clk_en_ff.per <= 1'b0;
          clk_en_ff.rtc <= 1'b1;
          clk_en_ff.osc <= 1'b1; // RULE_18
        end
        default: begin
          clk_en_ff.per <= 1'b0;
          clk_en_ff.rtc <= 1'b0;
          clk_en_ff.osc <= 1'b0; // RULE_11
        end
      endcase
    end
  end

  // mode in force: the captured one once asleep, the request on entry
  function automatic logic [2:0] sleep_mode_q(input spm_pkg::spm_state_t st,
                                              input logic [2:0] req,
                                              input logic [2:0] held);
    sleep_mode_q = (st == spm_pkg::SPM_ST_SLEEP) ? held : req;
  endfunction : sleep_mode_q

  // per-peripheral gates stack on top of the sleep gating
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      per_clk_en_ff <= '1;
    end else if (nxt_state == spm_pkg::SPM_ST_SLEEP && !rst_src_req &&
                 sleep_mode_q(state_ff, sleep_mode, mode_ff) != spm_pkg::SPM_MODE_IDLE) begin
      per_clk_en_ff <= '0;
    end else begin
      per_clk_en_ff <= ~per_off; // RULE_14 RULE_15
    end
  end

  int unsigned halt_len;
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      halt_len <= 0;
    end else if (state_ff == spm_pkg::SPM_ST_WAKE) begin
      halt_len <= halt_len + 1;
    end else begin
      halt_len <= 0;
    end
  end

  property p_wake_halt;
    @(posedge core_clk) disable iff (!rstn || rst_src_req)
    $rose(state_ff == spm_pkg::SPM_ST_WAKE) |-> (state_ff == spm_pkg::SPM_ST_WAKE) [*4]
      ##1 (state_ff == spm_pkg::SPM_ST_ACTIVE);
  endproperty
  a_wake_halt: assert property (p_wake_halt) else $error("wake halt not four cycles"); // RULE_05

  property p_halt_bound;
    @(posedge core_clk) disable iff (!rstn)
    halt_len <= 4;
  endproperty
  a_halt_bound: assert property (p_halt_bound) else $error("wake halt too long"); // RULE_05

  property p_no_sleep_dis;
    @(posedge core_clk) disable iff (!rstn || rst_src_req)
    (state_ff == spm_pkg::SPM_ST_ACTIVE && sleep_instr && !sleep_en && !usb_suspend)
      |=> state_ff == spm_pkg::SPM_ST_ACTIVE;
  endproperty
  a_no_sleep_dis: assert property (p_no_sleep_dis) else $error("slept without enable"); // RULE_17

  property p_enter;
    @(posedge core_clk) disable iff (!rstn || rst_src_req)
    (state_ff == spm_pkg::SPM_ST_ACTIVE && sleep_instr && sleep_en && mode_valid)
      |=> state_ff == spm_pkg::SPM_ST_SLEEP ##0 core_halt_ff;
  endproperty
  a_enter: assert property (p_enter) else $error("sleep not entered"); // RULE_02

  property p_reset_sleep;
    @(posedge core_clk) disable iff (!rstn)
    rst_src_req |=> core_reset_ff && state_ff == spm_pkg::SPM_ST_ACTIVE && !core_halt_ff;
  endproperty
  a_reset_sleep: assert property (p_reset_sleep) else $error("reset did not restart"); // RULE_07

  property p_pdown_clk;
    @(posedge core_clk) disable iff (!rstn)
    (state_ff == spm_pkg::SPM_ST_SLEEP && mode_pdown && $stable(state_ff))
      |-> !clk_en_ff.rtc && !clk_en_ff.per && !clk_en_ff.osc && !clk_en_ff.cpu &&
          !clk_en_ff.nvm;
  endproperty
  a_pdown_clk: assert property (p_pdown_clk) else $error("clock running in power-down"); // RULE_11

  property p_pdown_nosync;
    @(posedge core_clk) disable iff (!rstn || rst_src_req)
    (state_ff == spm_pkg::SPM_ST_SLEEP && mode_pdown && !async_sync2_ff)
      |=> state_ff == spm_pkg::SPM_ST_SLEEP;
  endproperty
  a_pdown_nosync: assert property (p_pdown_nosync) else $error("power-down woke on sync irq"); // RULE_12

  property p_async_wake;
    @(posedge core_clk) disable iff (!rstn || rst_src_req)
    // three sync stages, then one more edge for the state to move
    (state_ff == spm_pkg::SPM_ST_SLEEP && async_lvl) [*4] |=> state_ff == spm_pkg::SPM_ST_WAKE;
  endproperty
  a_async_wake: assert property (p_async_wake) else $error("async source did not wake"); // RULE_13

  property p_idle_clk;
    @(posedge core_clk) disable iff (!rstn)
    (state_ff == spm_pkg::SPM_ST_SLEEP && mode_idle && $stable(state_ff))
      |-> clk_en_ff.per && !clk_en_ff.cpu && per_clk_en_ff == ~$past(per_off);
  endproperty
  a_idle_clk: assert property (p_idle_clk) else $error("idle gating wrong"); // RULE_09

  property p_idle_irq_wake;
    @(posedge core_clk) disable iff (!rstn || rst_src_req)
    (state_ff == spm_pkg::SPM_ST_SLEEP && mode_idle && irq_sync_wake)
      |=> state_ff == spm_pkg::SPM_ST_WAKE;
  endproperty
  a_idle_irq_wake: assert property (p_idle_irq_wake) else $error("idle missed enabled irq"); // RULE_10

  property p_isr_after_halt;
    @(posedge core_clk) disable iff (!rstn)
    irq_service_ff |-> !core_halt_ff && $past(state_ff) == spm_pkg::SPM_ST_WAKE;
  endproperty
  a_isr_after_halt: assert property (p_isr_after_halt) else $error("irq released in halt"); // RULE_03

  property p_isr_pending;
    @(posedge core_clk) disable iff (!rstn || rst_src_req)
    (state_ff == spm_pkg::SPM_ST_ACTIVE && $past(state_ff) == spm_pkg::SPM_ST_WAKE &&
     $past(irq_pending) && !$past(rst_src_req)) |-> irq_service_ff;
  endproperty
  a_isr_pending: assert property (p_isr_pending) else $error("pending irq not released"); // RULE_04

  // active gating must follow the software stops with one cycle of lag
  property p_per_active;
    @(posedge core_clk) disable iff (!rstn)
    (state_ff == spm_pkg::SPM_ST_ACTIVE && $past(rstn))
      |-> per_clk_en_ff == ~$past(per_off);
  endproperty
  a_per_active: assert property (p_per_active) else $error("active gating wrong"); // RULE_14

  c_idle: cover property (@(posedge core_clk) disable iff (!rstn)
    state_ff == spm_pkg::SPM_ST_SLEEP && mode_idle ##1 state_ff == spm_pkg::SPM_ST_WAKE);
  c_pdown: cover property (@(posedge core_clk) disable iff (!rstn)
    state_ff == spm_pkg::SPM_ST_SLEEP && mode_pdown ##1 state_ff == spm_pkg::SPM_ST_WAKE);
  c_rst: cover property (@(posedge core_clk) disable iff (!rstn)
    state_ff == spm_pkg::SPM_ST_SLEEP && rst_src_req);
  c_isr: cover property (@(posedge core_clk) disable iff (!rstn) irq_service_ff);
  c_usb: cover property (@(posedge core_clk) disable iff (!rstn)
    state_ff == spm_pkg::SPM_ST_ACTIVE && usb_suspend ##1 state_ff == spm_pkg::SPM_ST_SLEEP);
endmodule : spm_sleep_ctrl
`default_nettype wire

// ==== verif/spm_core_model.sv ====
// partner model: core sleep instruction and asynchronous wake sources
`timescale 1ns/100ps
`default_nettype none
module spm_core_model (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic go_sleep,
  input wire spm_pkg::spm_async_t wake_cmd,
  input wire logic asleep_ff,
  output logic sleep_instr_ff,
  output spm_pkg::spm_async_t async_wake_ff
);
  logic was_asleep_ff;
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      sleep_instr_ff <= 1'b0;
      was_asleep_ff <= 1'b0;
      async_wake_ff <= '0;
    end else begin
      sleep_instr_ff <= go_sleep;
      was_asleep_ff <= asleep_ff;
      // sources hold their level until the wake is served
      if (was_asleep_ff && !asleep_ff) async_wake_ff <= '0;
      else async_wake_ff <= async_wake_ff | wake_cmd;
    end
  end
endmodule : spm_core_model
`default_nettype wire

// ==== verif/spm_sleep_ctrl_tb.sv ====
// self-checking bench for the sleep and power manager
`timescale 1ns/100ps
`default_nettype none
module spm_sleep_ctrl_tb;
  logic core_clk, rstn, go_sleep, sleep_en, nvm_busy, irq_pending, irq_sync_wake;
  logic rst_src_req, usb_suspend, usb_sleep_req, sleep_instr, core_halt_ff, core_reset_ff;
  logic irq_service_ff, asleep_ff;
  logic [2:0] sleep_mode;
  logic [7:0] per_off, per_clk_en_ff;
  spm_pkg::spm_async_t wake_cmd, async_wake;
  spm_pkg::spm_clk_t clk_en_ff;
  int bad_count, comparisons, cycles;
  logic [2:0] modes [5] = '{3'h0, 3'h2, 3'h3, 3'h6, 3'h7};

  spm_sleep_ctrl #(.NUM_PER(8)) u_spm_sleep_ctrl (.core_clk(core_clk), .rstn(rstn),
    .sleep_instr(sleep_instr), .sleep_en(sleep_en), .sleep_mode(sleep_mode),
    .nvm_busy(nvm_busy), .irq_pending(irq_pending), .irq_sync_wake(irq_sync_wake),
    .rst_src_req(rst_src_req), .usb_suspend(usb_suspend), .usb_sleep_req(usb_sleep_req),
    .async_wake(async_wake), .per_off(per_off), .core_halt_ff(core_halt_ff),
    .core_reset_ff(core_reset_ff), .irq_service_ff(irq_service_ff),
    .asleep_ff(asleep_ff), .clk_en_ff(clk_en_ff), .per_clk_en_ff(per_clk_en_ff));
  spm_core_model u_spm_core_model (.core_clk(core_clk), .rstn(rstn), .go_sleep(go_sleep),
    .wake_cmd(wake_cmd), .asleep_ff(asleep_ff), .sleep_instr_ff(sleep_instr),
    .async_wake_ff(async_wake));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task close_out;
    if (bad_count == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out

  // clock enables {cpu,nvm,per,rtc,osc} expected while asleep
  function logic [4:0] exp_clk(input logic [2:0] m, input logic busy);
    case (m)
      3'h0: return {1'b0, busy, 3'h7};
      3'h3: return 5'h02;
      3'h6: return 5'h01;
      3'h7: return 5'h03;
      default: return 5'h00;
    endcase
  endfunction : exp_clk

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      bad_count++;
      close_out();
    end
  end

  // src 0..2 picks one async source, 3 the clocked interrupt (idle only)
  task sleep_wake(input logic [2:0] m, input logic usb, input int src);
    int n;
    @(posedge core_clk);
    sleep_mode <= m;
    per_off <= 8'($urandom);
    irq_pending <= 1'($urandom);
    nvm_busy <= (src == 3);
    sleep_en <= 1'b1;
    usb_suspend <= usb;
    usb_sleep_req <= usb;
    go_sleep <= !usb;
    @(posedge core_clk);
    go_sleep <= 1'b0;
    usb_suspend <= 1'b0;
    usb_sleep_req <= 1'b0;
    if (!usb) @(posedge core_clk);
    #1 check(asleep_ff, 1'b1);
    check(core_halt_ff, 1'b1);
    check(clk_en_ff, exp_clk(m, src == 3));
    check(per_clk_en_ff, (m == 3'h0) ? 8'(~per_off) : 8'h00);
    if (src == 3) begin
      @(posedge core_clk);
      nvm_busy <= 1'b0;
      repeat (2) @(posedge core_clk);
      #1 check(clk_en_ff.nvm, 1'b0);
    end
    if (m == 3'h2) begin
      @(posedge core_clk);
      irq_sync_wake <= 1'b1;
      repeat (8) @(posedge core_clk);
      irq_sync_wake <= 1'b0;
      #1 check(asleep_ff, 1'b1);
    end
    @(posedge core_clk);
    if (src == 3) irq_sync_wake <= 1'b1;
    else wake_cmd <= spm_pkg::spm_async_t'(3'h1 << src);
    @(posedge core_clk);
    wake_cmd <= '0;
    #1 n = 0;
    while (asleep_ff === 1'b1 && n < 20) begin
      @(posedge core_clk);
      #1 n++;
    end
    check(n < 20, 1'b1);
    check(core_halt_ff, 1'b1);
    repeat (3) begin
      @(posedge core_clk);
      irq_sync_wake <= 1'b0;
      #1 check(core_halt_ff, 1'b1);
    end
    @(posedge core_clk);
    #1 check(core_halt_ff, 1'b0);
    check(irq_service_ff, irq_pending);
    check(clk_en_ff, 5'h1F);
    check(per_clk_en_ff, 8'(~per_off));
  endtask : sleep_wake

  initial begin
    {rstn, go_sleep, sleep_en, nvm_busy, irq_pending, irq_sync_wake} = '0;
    {rst_src_req, usb_suspend, usb_sleep_req} = '0;
    sleep_mode = 3'h0;
    per_off = 8'h00;
    wake_cmd = '0;
    bad_count = 0;
    comparisons = 0;
    cycles = 0;
    void'($urandom(32'hD02DCA5D));
    repeat (11) @(posedge core_clk);
    #1 check(core_reset_ff, 1'b1);
    check({core_halt_ff, asleep_ff, clk_en_ff, per_clk_en_ff}, 15'h1FFF);
    @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    #1 check(core_reset_ff, 1'b0);
    for (int i = 0; i < 5; i++) sleep_wake(modes[i], 1'b0, 1);
    sleep_wake(3'h0, 1'b0, 3);
    sleep_wake(3'h2, 1'b1, 0);
    // refused requests: enable low, then an unused mode code
    for (int i = 0; i < 2; i++) begin
      @(posedge core_clk);
      sleep_en <= (i == 1);
      sleep_mode <= (i == 0) ? 3'h0 : 3'h1;
      go_sleep <= 1'b1;
      @(posedge core_clk);
      go_sleep <= 1'b0;
      repeat (3) @(posedge core_clk);
      #1 check(asleep_ff, 1'b0);
    end
    @(posedge core_clk);
    sleep_mode <= 3'h7;
    go_sleep <= 1'b1;
    @(posedge core_clk);
    go_sleep <= 1'b0;
    repeat (4) @(posedge core_clk);
    rst_src_req <= 1'b1;
    #1 check(asleep_ff, 1'b1);
    @(posedge core_clk);
    rst_src_req <= 1'b0;
    #1 check({core_reset_ff, core_halt_ff, asleep_ff}, 3'h4);
    check(clk_en_ff, 5'h1F);
    @(posedge core_clk);
    #1 check(core_reset_ff, 1'b0);
    repeat (30) sleep_wake(modes[$urandom_range(4)], 1'($urandom), $urandom_range(2));
    close_out();
  end
endmodule : spm_sleep_ctrl_tb
`default_nettype wire
